/* wdg_top.sv */
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "wdg_map.svh"

// What this block does
// (R1) Counts ticks of a separate 128 kHz oscillator, not the system clock.
// (R2) On reaching the selected period, interrupts or resets per mode.
// (R3) Software restarts before expiry; each restart returns count to zero.
// (R4) Interrupt-only mode raises interrupt without reset; usable as wake-up.
// (R5) Reset-only mode issues a system reset on expiry.
// (R6) Combined mode interrupts first, then a later expiry resets.
// (R7) Programmed always-on fuse forces reset enable 1, interrupt enable 0.
// (R8) Reset enable clear or prescaler change only via timed unlock.
// (R9) Software opens unlock writing change enable and reset enable together.
// (R10) Within four cycles software writes new values with change enable 0.
// (R11) Selectable time-out from about 1 ms up to about 8 s.
// (R12) After a watchdog reset the watchdog remains enabled.
// (R13) Startup software should clear reset cause flag and reset enable.
// (R14) Reset cause flag forces reset enable on until it is cleared.
// (R15) Change enable self-clears four cycles after being written one.
// (R16) Combined mode vector clears interrupt enable and flag, leaving reset.
// (R17) Four-bit prescaler decodes 2048..1048576, then 1024..128, two reserved.
// (R18) Restart and configuration reach the counter only on oscillator ticks.
// (R19) Any system reset clears the count to zero.

module wdg_top #(
  parameter int unsigned OSC_DIV = `WDG_OSC_DIV,
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core and reset unit.
  input wire logic restart_i,
  input wire logic vector_ack_i,
  input wire logic reset_cause_flag_i,
  input wire logic always_on_fuse_i,
  // Outputs to the system.
  output logic sys_rst_o,
  output logic wake_o,
  output logic irq_o
);

  logic reset_enable_bit;
  logic next_re;
  logic timeout_irq_enable_bit;
  logic next_ie;
  logic timeout_irq_flag;
  logic next_flag;
  logic [3:0] prescaler_select_field;
  logic [3:0] next_psel;
  logic [2:0] win_cnt;
  logic [2:0] next_win;
  logic [`WDG_EV_W-1:0] status;
  logic [`WDG_EV_W-1:0] next_status;
  logic [`WDG_EV_W-1:0] mask;
  logic [`WDG_EV_W-1:0] next_mask;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_rst;
  logic next_wake;
  logic next_irq;
  logic re_eff;
  logic ie_eff;
  logic change_enable_bit;
  logic tick;
  logic expire;
  logic req;
  logic csr_wr;
  logic open_wr;
  logic [7:0] d;
  wdg_pkg::wdg_mode_type mode;

  // Oscillator strobe and the period counter.
  wdg_osc_tick #(
    .DIV(OSC_DIV)
  ) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  wdg_counter #(
    .CNT_W(CNT_W)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .restart_i(restart_i),
    .enable_i(mode != wdg_pkg::WDG_STOPPED),
    .psel_i(prescaler_select_field),
    .expire_o(expire)
  );

  // Effective enables: the fuse and the reset cause flag both pin reset
  // enable high, so a failing system keeps resetting instead of hanging.
  assign re_eff = reset_enable_bit | reset_cause_flag_i |
                  always_on_fuse_i; // (R12)
  assign ie_eff = timeout_irq_enable_bit & ~always_on_fuse_i; // (R7)
  assign mode = wdg_pkg::wdg_mode_of(re_eff, ie_eff);
  assign change_enable_bit = (win_cnt != 3'd0);

  // Bus request decode; ack is registered, so a new request is taken only
  // while ack is low and every access takes exactly one wait cycle.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign d = wb_dat_i[7:0];
  assign csr_wr = req & wb_we_i & wb_sel_i[0] &
                  (wb_adr_i == `WDG_CSR_ADDR);
  assign open_wr = csr_wr & d[`WDG_F_CE] & d[`WDG_F_RE];

  // Control register, unlock window and timeout consequences.
  always_comb begin
    next_re = reset_enable_bit;
    next_ie = timeout_irq_enable_bit;
    next_flag = timeout_irq_flag;
    next_psel = prescaler_select_field;
    next_win = change_enable_bit ? 3'(win_cnt - 3'd1) : 3'd0; // (R15)
    next_status = status;
    next_mask = mask;
    if (req && !wb_we_i && (wb_adr_i == `WDG_STATUS_ADDR)) begin
      next_status = '0;
    end
    if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `WDG_MASK_ADDR)) begin
      next_mask = d[`WDG_EV_W-1:0];
    end
    if (csr_wr) begin
      next_ie = d[`WDG_F_IE];
      if (d[`WDG_F_FLAG]) begin
        next_flag = 1'b0;
      end
      if (open_wr) begin
        next_win = `WDG_UNLOCK_CYCLES; // (R9)
        next_re = 1'b1;
      end else if (change_enable_bit && !d[`WDG_F_CE]) begin
        next_re = d[`WDG_F_RE]; // (R10)
        next_psel = {d[`WDG_F_P3], d[2:0]};
        next_win = 3'd0;
        next_status[`WDG_EV_UNLOCK] = 1'b1;
      end else begin
        // Outside the window reset enable can only be set. (R8)
        next_re = reset_enable_bit | d[`WDG_F_RE];
        if ((reset_enable_bit && !d[`WDG_F_RE]) ||
            ({d[`WDG_F_P3], d[2:0]} != prescaler_select_field)) begin
          next_status[`WDG_EV_REFUSED] = 1'b1;
        end
      end
    end
    if (vector_ack_i) begin
      next_flag = 1'b0;
      if (re_eff) begin
        next_ie = 1'b0; // (R16)
      end
    end
    // Hardware sets come last so an expiry beats a same-cycle clear.
    if (expire) begin
      next_status[`WDG_EV_TIMEOUT] = 1'b1;
      if (ie_eff) begin
        next_flag = 1'b1; // (R4)
      end
    end
  end

  // Reset decision and registered outputs.
  always_comb begin
    next_rst = 1'b0;
    if (expire) begin
      case (mode)
        wdg_pkg::WDG_RESET_MODE: next_rst = 1'b1; // (R5)
        wdg_pkg::WDG_COMBINED: next_rst = timeout_irq_flag; // (R6)
        default: next_rst = 1'b0;
      endcase
    end
    next_wake = next_flag & next_ie & ~always_on_fuse_i;
    next_irq = |(next_status & next_mask);
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == `WDG_CSR_ADDR) begin
        next_dat[7:0] = {timeout_irq_flag, ie_eff,
                         prescaler_select_field[3], change_enable_bit,
                         re_eff, prescaler_select_field[2:0]}; // (R14)
      end else if (wb_adr_i == `WDG_STATUS_ADDR) begin
        next_dat[`WDG_EV_W-1:0] = status;
      end else if (wb_adr_i == `WDG_MASK_ADDR) begin
        next_dat[`WDG_EV_W-1:0] = mask;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_enable_bit <= 1'b0;
      timeout_irq_enable_bit <= 1'b0;
      timeout_irq_flag <= 1'b0;
      prescaler_select_field <= `WDG_PSEL_RST;
      win_cnt <= 3'd0;
      status <= '0;
      mask <= `WDG_MASK_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      sys_rst_o <= 1'b0;
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      reset_enable_bit <= next_re;
      timeout_irq_enable_bit <= next_ie;
      timeout_irq_flag <= next_flag;
      prescaler_select_field <= next_psel;
      win_cnt <= next_win;
      status <= next_status;
      mask <= next_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      sys_rst_o <= next_rst;
      wake_o <= next_wake;
      irq_o <= next_irq;
    end
  end

  property p_irq_only;
    @(posedge clk_i) disable iff (rst_i)
      expire && (mode == wdg_pkg::WDG_IRQ_MODE) && !vector_ack_i
      |=> timeout_irq_flag && !sys_rst_o ##1 wake_o;
  endproperty
  a_irq_only: assert property (p_irq_only) // (R4)
    else $error("Interrupt mode expiry did not raise only the flag.");

  property p_reset_only;
    @(posedge clk_i) disable iff (rst_i)
      expire && re_eff && !ie_eff |=> sys_rst_o ##1 !sys_rst_o;
  endproperty
  a_reset_only: assert property (p_reset_only) // (R5)
    else $error("Reset mode expiry did not give a one-cycle reset.");

  property p_combined_first;
    @(posedge clk_i) disable iff (rst_i)
      expire && (mode == wdg_pkg::WDG_COMBINED) && !timeout_irq_flag
      |=> timeout_irq_flag && !sys_rst_o;
  endproperty
  a_combined_first: assert property (p_combined_first) // (R6)
    else $error("Combined mode first expiry did not interrupt.");

  property p_fuse_forces;
    @(posedge clk_i) disable iff (rst_i)
      always_on_fuse_i && expire |=> sys_rst_o && !wake_o;
  endproperty
  a_fuse_forces: assert property (p_fuse_forces) // (R7)
    else $error("Always-on fuse did not force reset on expiry.");

  property p_locked_clear;
    @(posedge clk_i) disable iff (rst_i)
      csr_wr && !change_enable_bit && !d[`WDG_F_CE] && reset_enable_bit
      |=> reset_enable_bit && $stable(prescaler_select_field);
  endproperty
  a_locked_clear: assert property (p_locked_clear) // (R8)
    else $error("Locked write changed reset enable or prescaler.");

  property p_window_closes;
    @(posedge clk_i) disable iff (rst_i)
      open_wr ##1 (!open_wr)[*4] |=> !change_enable_bit;
  endproperty
  a_window_closes: assert property (p_window_closes) // (R15)
    else $error("Change enable still set four cycles after opening.");

  property p_cause_keeps;
    @(posedge clk_i) disable iff (rst_i)
      reset_cause_flag_i && expire && !ie_eff |=> sys_rst_o;
  endproperty
  a_cause_keeps: assert property (p_cause_keeps) // (R14)
    else $error("Reset cause flag did not keep reset enabled.");

  property p_vector_clears;
    @(posedge clk_i) disable iff (rst_i)
      vector_ack_i && re_eff && !expire && !csr_wr
      |=> !timeout_irq_flag && !timeout_irq_enable_bit ##1 !wake_o;
  endproperty
  a_vector_clears: assert property (p_vector_clears) // (R16)
    else $error("Vector did not clear flag and enable in combined mode.");

endmodule : wdg_top

/* wdg_map.svh */
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define WDG_CSR_ADDR 8'h00
`define WDG_STATUS_ADDR 8'h04
`define WDG_MASK_ADDR 8'h08

// Field positions in the control and status register.
`define WDG_F_FLAG 7
`define WDG_F_IE 6
`define WDG_F_P3 5
`define WDG_F_CE 4
`define WDG_F_RE 3

// Event bits in the sticky status and mask registers.
`define WDG_EV_TIMEOUT 0
`define WDG_EV_UNLOCK 1
`define WDG_EV_REFUSED 2
`define WDG_EV_W 3

// Reset values.
`define WDG_PSEL_RST 4'h0
`define WDG_MASK_RST 3'h0

// Timing: unlock window, clock rates, code 0 period base, longest and shortest codes.
`define WDG_UNLOCK_CYCLES 3'd4
`define WDG_CLK_HZ 40000000
`define WDG_OSC_HZ 128000
`define WDG_OSC_DIV (`WDG_CLK_HZ / `WDG_OSC_HZ)
`define WDG_BASE_CYCLES 2048
`define WDG_CODE_LONGEST 4'd9
`define WDG_CODE_SHORTEST 4'd13

`endif

/* wdg_pkg.sv */
package wdg_pkg;

  // Operating mode as seen from the effective enable bits.
  typedef enum logic [1:0] {
    WDG_STOPPED,
    WDG_IRQ_MODE,
    WDG_RESET_MODE,
    WDG_COMBINED
  } wdg_mode_type;

  // Mode decode, shared by the timeout logic and the enable term.
  function automatic wdg_mode_type wdg_mode_of(input logic re,
                                               input logic ie);
    if (re && ie) begin
      wdg_mode_of = WDG_COMBINED;
    end else if (re) begin
      wdg_mode_of = WDG_RESET_MODE;
    end else if (ie) begin
      wdg_mode_of = WDG_IRQ_MODE;
    end else begin
      wdg_mode_of = WDG_STOPPED;
    end
  endfunction : wdg_mode_of

endpackage : wdg_pkg

/* wdg_osc_tick.sv */
`timescale 1ns/10ps
`include "wdg_map.svh"

module wdg_osc_tick #(
  parameter int unsigned DIV = `WDG_OSC_DIV
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // One pulse per oscillator period.
  output logic tick_o
);

  localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [DW-1:0] div;
  logic [DW-1:0] next_div;
  logic next_tick;

  // The slow oscillator is modelled as a strobe so the block stays on one
  // clock; the rate error from integer division is a fraction of a percent.
  always_comb begin
    next_tick = (div == DW'(DIV - 1));
    next_div = next_tick ? '0 : DW'(div + 1'b1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= '0;
      tick_o <= 1'b0;
    end else begin
      div <= next_div;
      tick_o <= next_tick;
    end
  end

  property p_tick_single;
    @(posedge clk_i) disable iff (rst_i)
      (DIV > 1) && tick_o |=> !tick_o;
  endproperty
  a_tick_single: assert property (p_tick_single) // (R1)
    else $error("Oscillator tick lasted more than one cycle.");

endmodule : wdg_osc_tick

/* wdg_counter.sv */
`timescale 1ns/10ps
`include "wdg_map.svh"

module wdg_counter #(
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Oscillator strobe and core-side requests.
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic enable_i,
  input wire logic [3:0] psel_i,
  // One-cycle pulse when the selected period has run out.
  output logic expire_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic pend;
  logic next_pend;
  logic en_q;
  logic next_en_q;
  logic [3:0] psel_q;
  logic [3:0] next_psel_q;
  logic next_exp;

  // Period in oscillator cycles for a prescaler code.
  function automatic logic [CNT_W:0] period_of(input logic [3:0] code);
    logic [CNT_W:0] b;
    b = (CNT_W + 1)'(`WDG_BASE_CYCLES);
    if (code <= `WDG_CODE_LONGEST) begin // (R17)
      period_of = b << code;
    end else if (code <= `WDG_CODE_SHORTEST) begin // (R11)
      period_of = b >> (4'(code - `WDG_CODE_LONGEST));
    end else begin
      period_of = b; // Reserved codes fall back to the base period.
    end
  endfunction : period_of

  // Requests are held until the next oscillator strobe and only then act
  // on the count, as they would crossing into a real slow domain.
  always_comb begin
    next_cnt = cnt;
    next_exp = 1'b0;
    next_pend = pend | restart_i;
    next_en_q = en_q;
    next_psel_q = psel_q;
    if (tick_i) begin
      next_pend = 1'b0; // (R18)
      next_en_q = enable_i;
      next_psel_q = psel_i;
      if (!en_q || pend || restart_i) begin
        next_cnt = '0; // (R3)
      end else if ({1'b0, cnt} >= period_of(psel_q) - 1'b1) begin
        // A shortened period may already be passed; expire at once.
        next_cnt = '0;
        next_exp = 1'b1; // (R2)
      end else begin
        next_cnt = CNT_W'(cnt + 1'b1); // (R1)
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0; // (R19)
      pend <= 1'b0;
      en_q <= 1'b0;
      psel_q <= `WDG_PSEL_RST;
      expire_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pend <= next_pend;
      en_q <= next_en_q;
      psel_q <= next_psel_q;
      expire_o <= next_exp;
    end
  end

  property p_restart_zero;
    @(posedge clk_i) disable iff (rst_i)
      tick_i && (restart_i || pend) |=> (cnt == '0) && !expire_o;
  endproperty
  a_restart_zero: assert property (p_restart_zero) // (R3)
    else $error("Restart did not return the count to zero.");

  property p_reset_clears;
    @(posedge clk_i) rst_i |=> (cnt == '0) && !expire_o;
  endproperty
  a_reset_clears: assert property (p_reset_clears) // (R19)
    else $error("System reset did not clear the count.");

  property p_expire_at_limit;
    @(posedge clk_i) disable iff (rst_i)
      expire_o |-> $past(tick_i) && (cnt == '0);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) // (R2)
    else $error("Expiry not tied to a strobe and a cleared count.");

endmodule : wdg_counter

/* wdg_core_model.sv */
`timescale 1ns/10ps

// Core-side model: a classic Wishbone master plus the core strobes.
module wdg_core_model (
  // Clock.
  input wire logic clk_i,
  // Wishbone answer.
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  // Wishbone request.
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  // Core strobes.
  output logic restart_o,
  output logic vector_ack_o
);
  // The bus starts idle.
  initial begin
    wb_cyc_o = 1'h0;
    wb_stb_o = 1'h0;
    wb_we_o = 1'h0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
    restart_o = 1'h0;
    vector_ack_o = 1'h0;
  end

  // One classic cycle; on release address and data are inverted so no stale value lingers.
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [7:0] dat, output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'h1;
    wb_stb_o <= 1'h1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h00_0000, dat};
    do @(posedge clk_i); while (wb_ack_i !== 1'h1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'h0;
    wb_stb_o <= 1'h0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~{24'h00_0000, dat};
  endtask : xfer

  // Timed unlock; a gap of two or more cycles lets the window lapse on purpose.
  task automatic unlock(input logic [7:0] keep, input logic [7:0] val,
                        input int gap);
    logic [7:0] q;
    xfer(1'h1, 8'h00, keep | 8'h18, q);
    repeat (gap) @(posedge clk_i);
    xfer(1'h1, 8'h00, val & 8'hef, q);
  endtask : unlock

  // The restart instruction lasts one core cycle.
  task automatic restart();
    @(posedge clk_i);
    restart_o <= 1'h1;
    @(posedge clk_i);
    restart_o <= 1'h0;
  endtask : restart

  // Entry into the timeout vector lasts one core cycle.
  task automatic vector();
    @(posedge clk_i);
    vector_ack_o <= 1'h1;
    @(posedge clk_i);
    vector_ack_o <= 1'h0;
  endtask : vector
endmodule : wdg_core_model

/* tb_wdg_top.sv */
`timescale 1ns/10ps

module tb_wdg_top;
  // One step of the register walk.
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
    logic irq;
  } wdg_row_type;
  // A short oscillator divider keeps the run brief.
  localparam int D = 2;
  localparam int P = 128 * D;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cause = 1'h0;
  logic fuse = 1'h0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, restart, vec, sys_rst, wake, irq;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [7:0] q;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int rst_cnt = 0;
  int n, m;
  wdg_row_type rows [8] = '{
    '{1'h1, 8'h08, 8'h07, 8'h00, 1'h0}, '{1'h0, 8'h08, 8'h00, 8'h07, 1'h0},
    '{1'h1, 8'h0c, 8'hff, 8'h00, 1'h0}, '{1'h0, 8'h0c, 8'h00, 8'h00, 1'h0},
    '{1'h1, 8'h00, 8'h45, 8'h00, 1'h1}, '{1'h0, 8'h00, 8'h00, 8'h40, 1'h1},
    '{1'h0, 8'h04, 8'h00, 8'h04, 1'h0}, '{1'h0, 8'h04, 8'h00, 8'h00, 1'h0}};

  // Free-running system clock.
  always #12.5 clk_i = ~clk_i;

  wdg_top #(.OSC_DIV(D), .CNT_W(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .restart_i(restart),
    .vector_ack_i(vec), .reset_cause_flag_i(cause),
    .always_on_fuse_i(fuse), .sys_rst_o(sys_rst), .wake_o(wake),
    .irq_o(irq));

  wdg_core_model core_u (.clk_i(clk_i), .wb_ack_i(wb_ack),
    .wb_dat_i(wb_dat_r), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
    .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
    .wb_dat_o(wb_dat_w), .restart_o(restart), .vector_ack_o(vec));

  task automatic stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  // Expiry may lag a restart by up to one tick plus the output register.
  task automatic period_ok(input int n);
    chk_bit(n >= P - 2 * D && n <= P + 2 * D + 4, 1'h1);
  endtask : period_ok

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    core_u.xfer(1'h0, a, 8'h00, q);
    chk_val(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_u.xfer(1'h1, a, d, q);
  endtask : wr

  // Counts cycles until the wake level or the reset pulse shows.
  task automatic wait_for(input logic sel, output int n);
    n = 0;
    while ((sel ? sys_rst : wake) !== 1'h1 && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : wait_for

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    #1;
  endtask : do_reset

  // Reset pulses are counted, and a hung run is cut short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sys_rst === 1'h1) begin
      rst_cnt <= rst_cnt + 1;
    end
    if (cycles == 10000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    do_reset();
    chk_val({5'h00, sys_rst, wake, irq}, 8'h00);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      core_u.xfer(rows[i].we, rows[i].adr, rows[i].dat, q);
      #1;
      if (!rows[i].we) chk_val(q, rows[i].exp);
      chk_bit(irq, rows[i].irq);
    end
    // A proper unlock clears reset enable and picks the shortest period.
    core_u.unlock(8'h00, 8'h25, 0);
    rd(8'h00, 8'h25);
    rd(8'h04, 8'h02);
    // A commit after the window lapsed is refused.
    core_u.unlock(8'h25, 8'h25, 3);
    rd(8'h00, 8'h2d);
    core_u.xfer(1'h0, 8'h04, 8'h00, q);
    chk_val(q & 8'h04, 8'h04);
    // Reset mode at code 13, then timely restarts hold it off.
    core_u.restart();
    wait_for(1'h1, n);
    period_ok(n);
    chk_bit(wake, 1'h0);
    // The pulse is counted at the edge after it shows; take the base then.
    @(posedge clk_i);
    #1;
    m = rst_cnt;
    repeat (3) begin
      core_u.restart();
      repeat (P - 60) @(posedge clk_i);
    end
    chk_bit(rst_cnt == m, 1'h1);
    // Interrupt mode wakes the core and never resets.
    core_u.unlock(8'h25, 8'h65, 0);
    rd(8'h00, 8'h65);
    core_u.restart();
    m = rst_cnt;
    wait_for(1'h0, n);
    period_ok(n);
    chk_bit(rst_cnt == m, 1'h1);
    core_u.vector();
    @(posedge clk_i);
    #1;
    chk_bit(wake, 1'h0);
    rd(8'h00, 8'h65);
    // Combined mode interrupts first and resets on the next expiry.
    wr(8'h00, 8'h6d);
    core_u.restart();
    m = rst_cnt;
    wait_for(1'h0, n);
    period_ok(n);
    chk_bit(rst_cnt == m, 1'h1);
    wait_for(1'h1, n);
    period_ok(n);
    core_u.vector();
    rd(8'h00, 8'h2d);
    // The fuse locks reset mode against writes.
    @(posedge clk_i) fuse <= 1'h1;
    wr(8'h00, 8'h65);
    rd(8'h00, 8'h2d);
    core_u.restart();
    wait_for(1'h1, n);
    period_ok(n);
    chk_bit(wake, 1'h0);
    @(posedge clk_i) fuse <= 1'h0;
    // A set reset cause keeps reset enable on across reset and unlock.
    @(posedge clk_i) cause <= 1'h1;
    do_reset();
    chk_val({5'h00, sys_rst, wake, irq}, 8'h00);
    rd(8'h00, 8'h08);
    core_u.unlock(8'h00, 8'h25, 0);
    rd(8'h00, 8'h2d);
    core_u.restart();
    wait_for(1'h1, n);
    period_ok(n);
    @(posedge clk_i) cause <= 1'h0;
    rd(8'h00, 8'h25);
    stop_test();
  end
endmodule : tb_wdg_top
